// [keypad_pkg.sv]
// Shared constants for the keypad mask and result logic
package keypad_pkg;

   // Matrix geometry
   localparam int NUM_COLS = 6; // Columns of the keypad
   localparam int NUM_ROWS = 5; // Rows of the keypad
   localparam int NUM_KEYS = 30; // Keys numbered 1 to 30

   // Register pages and offsets
   localparam logic PAGE_RESULT = 1'h0; // Page holding results
   localparam logic PAGE_CTRL = 1'h1; // Page holding masks and trigger
   localparam logic [4:0] ADDR_RESULT_COL = 5'h00; // Column filtered result
   localparam logic [4:0] ADDR_RESULT_FULL = 5'h01; // Fully filtered result
   localparam logic [4:0] ADDR_KEY_MASK_LOW = 5'h01; // Masks for keys 1..15
   localparam logic [4:0] ADDR_KEY_MASK_HIGH = 5'h02; // Masks for keys 16..30
   localparam logic [4:0] ADDR_COLUMN_DISABLE = 5'h03; // Column disables
   localparam logic [4:0] ADDR_SCAN_TRIGGER = 5'h04; // Scan trigger command

   // Reset values
   localparam logic [15:0] KEY_MASK_RESET = 16'h0000; // Masks off
   localparam logic [15:0] COLUMN_DISABLE_RESET = 16'h0000; // All columns on
   localparam logic [15:0] RESULT_RESET = 16'h0000; // No key reported

   // Result field positions
   localparam int ERR_BIT = 15; // Error flag
   localparam int CODE_THIRD_LSB = 10; // Third key code 14:10
   localparam int CODE_SECOND_LSB = 5; // Second key code 9:5
   localparam int CODE_FIRST_LSB = 0; // First key code 4:0
   localparam int CODE_W = 5; // Width of one key code
   localparam int MAX_SLOTS = 3; // Keys reported at most
   localparam int ERR_KEY_COUNT = 4; // More keys than this is an error
   localparam logic [4:0] ERR_CODE = 5'h1F; // Code 31 on error
   localparam int MASK_BITS = 15; // Valid bits of a key mask register

   // Timing
   localparam int CLK_MHZ = 200; // System clock rate
   localparam int DEBOUNCE_TIME_US = 1000; // Default debounce interval
   localparam int HOLD_TIME_US = 100; // Default hold time
   localparam int DEBOUNCE_CYCLES_DEF = DEBOUNCE_TIME_US * CLK_MHZ; // Cycles
   localparam int HOLD_CYCLES_DEF = HOLD_TIME_US * CLK_MHZ; // Cycles

   // Scanner states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_DEBOUNCE = 5'h02,
      ST_HOLD = 5'h04,
      ST_WAIT_READ = 5'h08,
      ST_SPARE = 5'h10
   } scan_state_t;

endpackage : keypad_pkg

// [keypad_scan_result.sv]
// Keypad scanner mask, trigger, sequencing and result registers
//
// Summary of operation
// - Key masks clear only fully filtered results
// - Mask registers 01H/02H, bit 15 zero
// - Column disable bit removes column from detection
// - Host mode: only trigger write starts scan
// - Accepted trigger clears both result registers
// - Keys numbered down columns, 1 to 30
// - Code zero means empty slot
// - Up to three keys fill slots in order
// - Over four keys: error flags, codes 31
// - Result one column filtered, two fully filtered
// - Each result register clears when read
// - Error bit 15, codes 14:10, 9:5, 4:0
// - Results page 0, masks and trigger page 1
// - Key-press mode: press lowers irq, starts scan
// - Hold after scan, read restarts hold
module keypad_scan_result
   import keypad_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYCLES_DEF, // Debounce length
   parameter int unsigned HOLD_CYCLES = HOLD_CYCLES_DEF // Hold length
) (
   input wire logic sys_clk_i, // 200 MHz system clock
   input wire logic rst_i, // Synchronous reset, active high
   input wire logic [NUM_KEYS-1:0] key_matrix_i, // Raw key state, bit k is key k+1
   input wire logic host_scan_select_i, // High selects host-started scans
   input wire logic reg_wr_i, // Register write strobe
   input wire logic reg_rd_i, // Register read strobe
   input wire logic reg_page_i, // Register page
   input wire logic [4:0] reg_addr_i, // Register address in page
   input wire logic [15:0] reg_wdata_i, // Write data
   output logic [15:0] reg_rdata_o, // Read data
   output logic reg_rvalid_o, // Read data valid pulse
   output logic key_irq_n_a_o // Key interrupt, active low
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [NUM_KEYS-1:0] key_s1_ff; // First sync stage
   logic [NUM_KEYS-1:0] key_s2_ff; // Second sync stage
   logic [NUM_KEYS-1:0] key_s3_ff; // Third sync stage
   logic [NUM_KEYS-1:0] key_stable_ff; // Accepted key state
   logic [15:0] key_mask_low_ff; // Masks keys 1..15
   logic [15:0] key_mask_high_ff; // Masks keys 16..30
   logic [15:0] column_disable_ff; // Column disable bits
   logic [15:0] result_col_ff; // Column filtered result
   logic [15:0] result_full_ff; // Fully filtered result
   logic [15:0] rdata_ff; // Read data register
   logic rvalid_ff; // Read valid register
   logic irq_n_ff; // Interrupt output register
   logic [31:0] count_ff; // Debounce and hold counter
   scan_state_t state_ff; // Scanner state
   scan_state_t nxt_state; // Next scanner state

   ////////////////////////////////////////////////////////////////////////
   // Helper functions

   // Pack the first three set keys into code slots
   function automatic logic [14:0] pack_codes(input logic [NUM_KEYS-1:0] v);
      logic [14:0] r;
      int n;
      r = '0;
      n = 0;
      for (int i = 0; i < NUM_KEYS; i++) begin
         if (v[i] && n < MAX_SLOTS) begin
            r[n*CODE_W +: CODE_W] = CODE_W'(i + 1);
            n++;
         end
      end
      return r;
   endfunction

   // Count the keys held down
   function automatic int count_keys(input logic [NUM_KEYS-1:0] v);
      int n;
      n = 0;
      for (int i = 0; i < NUM_KEYS; i++) begin
         n += int'(v[i]);
      end
      return n;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Decode and filtering

   wire sel_res_col = reg_page_i == PAGE_RESULT && reg_addr_i == ADDR_RESULT_COL;
   wire sel_res_full = reg_page_i == PAGE_RESULT && reg_addr_i == ADDR_RESULT_FULL;
   wire sel_mask_low = reg_page_i == PAGE_CTRL && reg_addr_i == ADDR_KEY_MASK_LOW;
   wire sel_mask_high = reg_page_i == PAGE_CTRL && reg_addr_i == ADDR_KEY_MASK_HIGH;
   wire sel_col_dis = reg_page_i == PAGE_CTRL && reg_addr_i == ADDR_COLUMN_DISABLE;
   wire sel_trigger = reg_page_i == PAGE_CTRL && reg_addr_i == ADDR_SCAN_TRIGGER;
   wire rd_col = reg_rd_i && sel_res_col; // Host reads result one
   wire rd_full = reg_rd_i && sel_res_full; // Host reads result two
   wire result_read = rd_col || rd_full; // Any result read
   // Data bits of the trigger write are ignored
   wire trig_wr = reg_wr_i && sel_trigger;

   // Column enable per key: key k sits in column (k-1) / rows
   wire [NUM_KEYS-1:0] col_keep; // Key column enabled
   wire [NUM_KEYS-1:0] key_mask_all; // Per-key mask in key order
   wire [NUM_KEYS-1:0] keys_col; // Column filtered keys
   wire [NUM_KEYS-1:0] keys_full; // Column and key filtered keys
   genvar g;
   generate
      for (g = 0; g < NUM_KEYS; g++) begin : g_key
         assign col_keep[g] = !column_disable_ff[g / NUM_ROWS];
      end
   endgenerate
   assign key_mask_all = {key_mask_high_ff[MASK_BITS-1:0], key_mask_low_ff[MASK_BITS-1:0]};
   assign keys_col = key_stable_ff & col_keep;
   assign keys_full = keys_col & ~key_mask_all;

   wire any_key = |keys_col; // Detectable press present
   wire too_many = count_keys(keys_col) > ERR_KEY_COUNT;
   wire [15:0] err_word = {1'b1, ERR_CODE, ERR_CODE, ERR_CODE};
   wire [15:0] new_col = too_many ? err_word : {1'b0, pack_codes(keys_col)};
   wire [15:0] new_full = too_many ? err_word : {1'b0, pack_codes(keys_full)};

   // Sequencer decisions
   wire idle = state_ff == ST_IDLE; // Ready to detect
   wire start_key = idle && !host_scan_select_i && any_key;
   wire start_host = idle && host_scan_select_i && trig_wr;
   wire deb_done = state_ff == ST_DEBOUNCE && count_ff == DEBOUNCE_CYCLES - 1;
   wire hold_done = state_ff == ST_HOLD && count_ff == HOLD_CYCLES - 1;

   ////////////////////////////////////////////////////////////////////////
   // Key input synchroniser; a change counts once stages two and three agree

   always_ff @(posedge sys_clk_i) begin
      key_s1_ff <= key_matrix_i;
      key_s2_ff <= key_s1_ff;
      key_s3_ff <= key_s2_ff;
   end

   // Accept only bits whose last two stages agree
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         key_stable_ff <= '0;
      end else begin
         key_stable_ff <= (key_s2_ff & key_s3_ff) | (key_stable_ff & (key_s2_ff | key_s3_ff));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Software written mask registers

   // Bit 15 is never stored, so it always reads zero
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         key_mask_low_ff <= KEY_MASK_RESET;
         key_mask_high_ff <= KEY_MASK_RESET;
         column_disable_ff <= COLUMN_DISABLE_RESET;
      end else if (reg_wr_i) begin
         if (sel_mask_low) begin
            key_mask_low_ff <= {1'b0, reg_wdata_i[MASK_BITS-1:0]};
         end
         if (sel_mask_high) begin
            key_mask_high_ff <= {1'b0, reg_wdata_i[MASK_BITS-1:0]};
         end
         if (sel_col_dis) begin
            column_disable_ff <= {10'h000, reg_wdata_i[NUM_COLS-1:0]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Scanner state machine

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (start_key || start_host) begin
               nxt_state = ST_DEBOUNCE;
            end
         end
         ST_DEBOUNCE: begin
            if (deb_done) begin
               nxt_state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (hold_done && !result_read) begin
               nxt_state = ST_WAIT_READ;
            end
         end
         ST_WAIT_READ: begin
            if (result_read) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_SPARE: begin
            nxt_state = ST_IDLE; // Unused code recovers
         end
      endcase
   end

   // State register and shared counter
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_ff <= ST_IDLE;
         count_ff <= 32'h00000000;
      end else begin
         state_ff <= nxt_state;
         // Counter restarts on every state change and on a read in hold
         if (nxt_state != state_ff || (state_ff == ST_HOLD && result_read)) begin
            count_ff <= 32'h00000000;
         end else begin
            count_ff <= count_ff + 32'h00000001;
         end
      end
   end

   // Interrupt low from press until the scan ends
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         irq_n_ff <= 1'b1;
      end else if (start_key) begin
         irq_n_ff <= 1'b0;
      end else if (deb_done) begin
         irq_n_ff <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Result registers; a scan load wins over a read clear

   // Matrix is sampled once, at the end of debounce
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         result_col_ff <= RESULT_RESET;
         result_full_ff <= RESULT_RESET;
      end else if (deb_done) begin
         result_col_ff <= new_col;
         result_full_ff <= new_full;
      end else if (start_host) begin
         result_col_ff <= RESULT_RESET;
         result_full_ff <= RESULT_RESET;
      end else begin
         if (rd_col) begin
            result_col_ff <= RESULT_RESET;
         end
         if (rd_full) begin
            result_full_ff <= RESULT_RESET;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path; unmapped and write-only addresses read zero

   wire [15:0] rd_mux = sel_res_col ? result_col_ff :
                        sel_res_full ? result_full_ff :
                        sel_mask_low ? key_mask_low_ff :
                        sel_mask_high ? key_mask_high_ff :
                        sel_col_dis ? column_disable_ff : 16'h0000;

   // Data appears the cycle after the strobe
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rdata_ff <= 16'h0000;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= reg_rd_i;
         if (reg_rd_i) begin
            rdata_ff <= rd_mux;
         end
      end
   end

   assign reg_rdata_o = rdata_ff; // Straight from flop
   assign reg_rvalid_o = rvalid_ff; // Straight from flop
   assign key_irq_n_a_o = irq_n_ff; // Straight from flop

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_scan_end;
      state_ff == ST_DEBOUNCE && count_ff == DEBOUNCE_CYCLES - 1;
   endsequence
   sequence s_hold_entered;
      state_ff == ST_HOLD ##0 key_irq_n_a_o;
   endsequence

   property p_mask_reset;
      $past(rst_i) && !rst_i |-> key_mask_low_ff == 16'h0000 && key_mask_high_ff == 16'h0000;
   endproperty
   a_mask_reset: assert property (disable iff (1'b0) p_mask_reset)
      else $error("key masks not zero after reset");

   property p_mask_top_zero;
      rvalid_ff && $past(sel_mask_low || sel_mask_high) |-> !reg_rdata_o[15];
   endproperty
   a_mask_top_zero: assert property (p_mask_top_zero)
      else $error("mask bit 15 read as one");

   property p_col_disabled;
      column_disable_ff[0] |-> keys_col[4:0] == 5'h00;
   endproperty
   a_col_disabled: assert property (p_col_disabled)
      else $error("disabled column still detected");

   property p_host_no_auto;
      idle && host_scan_select_i && !trig_wr |=> state_ff == ST_IDLE;
   endproperty
   a_host_no_auto: assert property (p_host_no_auto)
      else $error("scan started without trigger in host mode");

   property p_trigger_clears;
      start_host |=> result_col_ff == 16'h0000 && result_full_ff == 16'h0000
         && state_ff == ST_DEBOUNCE;
   endproperty
   a_trigger_clears: assert property (p_trigger_clears)
      else $error("trigger did not clear results");

   property p_slot_order;
      result_col_ff[9:5] != 5'h00 |-> result_col_ff[4:0] != 5'h00;
   endproperty
   a_slot_order: assert property (p_slot_order)
      else $error("second slot filled before first");

   property p_error_codes;
      deb_done && too_many |=> result_full_ff == 16'hFFFF && result_col_ff == 16'hFFFF;
   endproperty
   a_error_codes: assert property (p_error_codes)
      else $error("error flag without code 31 fields");

   property p_read_clears;
      rd_col && !deb_done && !start_host |=> result_col_ff == 16'h0000;
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("result one not cleared by read");

   property p_press_irq;
      start_key |=> !key_irq_n_a_o && state_ff == ST_DEBOUNCE;
   endproperty
   a_press_irq: assert property (p_press_irq)
      else $error("key press did not lower interrupt");

   property p_hold_after_scan;
      s_scan_end |=> s_hold_entered;
   endproperty
   a_hold_after_scan: assert property (p_hold_after_scan)
      else $error("no hold with interrupt high after scan");

endmodule // keypad_scan_result

// [keypad_matrix_model.sv]
// Behavioural keypad matrix standing on the far side of the scanner
module keypad_matrix_model (
   input wire logic sys_clk_i, // Bench clock
   input wire logic [29:0] pressed_i, // Keys held by the user, bit k is key k+1
   input wire logic [3:0] settle_i, // Contact settle time in cycles, 0 is prompt
   output logic [29:0] key_matrix_o // Levels seen at the scanner pins
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [29:0] last_ff; // Last requested key set
   int cnt_ff; // Cycles left before contacts settle

   ////////////////////////////////////////////////////////////////////////////////
   // Contacts follow the user only after the settle time, so slow keys are modelled
   initial begin
      key_matrix_o = '0;
      last_ff = '0;
      cnt_ff = 0;
   end

   // Key k sits at bit k-1, numbered down each column
   always @(posedge sys_clk_i) begin
      if (pressed_i !== last_ff) begin
         last_ff <= pressed_i;
         cnt_ff <= settle_i;
      end else if (cnt_ff > 0) begin
         cnt_ff <= cnt_ff - 1;
      end else begin
         key_matrix_o <= last_ff;
      end
   end
endmodule // keypad_matrix_model

// [test_keypad_mask_and_result_logic.sv]
// Self-checking bench for the keypad mask and result logic
module test_keypad_mask_and_result_logic import keypad_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int DEB = 20; // Shortened debounce
   localparam int HLD = 10; // Shortened hold

   logic sys_clk_i = 1'b0; // 200 MHz clock
   logic rst_i = 1'b1; // Synchronous reset
   logic [29:0] key_matrix_i; // From the matrix model
   logic host_scan_select_i = 1'b0; // Scan start mode
   logic reg_wr_i = 1'b0; // Write strobe
   logic reg_rd_i = 1'b0; // Read strobe
   logic reg_page_i = 1'b0; // Page
   logic [4:0] reg_addr_i = 5'h00; // Address
   logic [15:0] reg_wdata_i = 16'h0000; // Write data
   logic [15:0] reg_rdata_o; // Read data
   logic reg_rvalid_o; // Read valid
   logic key_irq_n_a_o; // Key interrupt
   logic [29:0] press = '0; // Keys held by the user
   logic [3:0] settle = 4'h0; // Contact settle time
   int n_fail = 0; // Mismatches
   int tests_run = 0; // Comparisons

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, design and far-side model
   always #2.5 sys_clk_i = ~sys_clk_i;

   keypad_scan_result #(.DEBOUNCE_CYCLES(DEB), .HOLD_CYCLES(HLD)) dut_u (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .key_matrix_i(key_matrix_i),
      .host_scan_select_i(host_scan_select_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_page_i(reg_page_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .key_irq_n_a_o(key_irq_n_a_o));

   keypad_matrix_model matrix_u (
      .sys_clk_i(sys_clk_i), .pressed_i(press), .settle_i(settle),
      .key_matrix_o(key_matrix_i));

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers
   task test_done();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Compare and count; a mismatch is reported at once
   task check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Let n edges pass, then step off the edge
   task step(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask

   // Key bit for key number k
   function automatic logic [29:0] kb(input int k);
      return 30'h1 << (k - 1);
   endfunction

   // Result word built from three codes, error clear
   function automatic logic [15:0] code(input logic [4:0] a, b, c);
      return {1'b0, c, b, a};
   endfunction

   // One write cycle; strobe held across exactly one taking edge
   task wr(input logic pg, input logic [4:0] ad, input logic [15:0] d);
      reg_page_i = pg;
      reg_addr_i = ad;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      step(1);
      reg_wr_i = 1'b0;
   endtask

   // One read cycle; data taken when the valid pulse shows
   task rd(input logic pg, input logic [4:0] ad, input logic [15:0] exp);
      int i;
      reg_page_i = pg;
      reg_addr_i = ad;
      reg_rd_i = 1'b1;
      step(1);
      reg_rd_i = 1'b0;
      for (i = 0; i < 4 && reg_rvalid_o !== 1'b1; i++) step(1);
      if (i == 4) begin
         check(16'h0000, 16'hDEAD);
         test_done();
      end
      check(reg_rdata_o, exp);
   endtask

   // Wait for the interrupt level under a bound
   task wait_irq(input logic lvl, input int lim);
      int i;
      for (i = 0; i < lim && key_irq_n_a_o !== lvl; i++) step(1);
      if (i == lim) begin
         check({15'h0, key_irq_n_a_o}, {15'h0, lvl});
         test_done();
      end
   endtask

   // Full scan: press, start, read both results, then release and rearm
   task scan(input logic [29:0] keys, input logic host, input logic [15:0] e1, e2);
      press = keys;
      if (host) begin
         step(DEB);
         check({15'h0, key_irq_n_a_o}, 16'h0001);
         rd(PAGE_RESULT, ADDR_RESULT_COL, 16'h0000);
         wr(PAGE_CTRL, ADDR_SCAN_TRIGGER, 16'hFFFF);
         step(DEB + 6);
      end else begin
         wait_irq(1'b0, 12);
         wait_irq(1'b1, DEB + 8);
      end
      rd(PAGE_RESULT, ADDR_RESULT_COL, e1);
      rd(PAGE_RESULT, ADDR_RESULT_FULL, e2);
      rd(PAGE_RESULT, ADDR_RESULT_COL, 16'h0000);
      press = '0;
      step(HLD + 8);
      rd(PAGE_RESULT, ADDR_RESULT_FULL, 16'h0000);
      step(6);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      step(16);
      rst_i = 1'b0;
      step(4);
      // Reset state and register map
      check({15'h0, key_irq_n_a_o}, 16'h0001);
      rd(PAGE_CTRL, ADDR_KEY_MASK_LOW, KEY_MASK_RESET);
      rd(PAGE_CTRL, ADDR_KEY_MASK_HIGH, KEY_MASK_RESET);
      rd(PAGE_CTRL, ADDR_COLUMN_DISABLE, COLUMN_DISABLE_RESET);
      rd(PAGE_RESULT, ADDR_RESULT_COL, RESULT_RESET);
      rd(PAGE_CTRL, 5'h05, 16'h0000);
      rd(PAGE_CTRL, ADDR_SCAN_TRIGGER, 16'h0000);
      wr(PAGE_RESULT, ADDR_RESULT_FULL, 16'h1234);
      rd(PAGE_RESULT, ADDR_RESULT_FULL, 16'h0000);
      $display("test reset done");
      // Single, three, four and five keys
      scan(kb(1), 1'b0, code(1, 0, 0), code(1, 0, 0));
      settle = 4'h3;
      scan(kb(7) | kb(12) | kb(30), 1'b0, code(7, 12, 30), code(7, 12, 30));
      settle = 4'h0;
      scan(kb(2) | kb(9) | kb(20) | kb(26), 1'b0, code(2, 9, 20), code(2, 9, 20));
      scan(kb(1) | kb(6) | kb(11) | kb(16) | kb(21), 1'b0, 16'hFFFF, 16'hFFFF);
      $display("test key count done");
      // Key masks hit only the fully filtered word
      wr(PAGE_CTRL, ADDR_KEY_MASK_LOW, 16'hFFFF);
      rd(PAGE_CTRL, ADDR_KEY_MASK_LOW, 16'h7FFF);
      wr(PAGE_CTRL, ADDR_KEY_MASK_LOW, 16'h0040);
      wr(PAGE_CTRL, ADDR_KEY_MASK_HIGH, 16'h4000);
      rd(PAGE_CTRL, ADDR_KEY_MASK_HIGH, 16'h4000);
      scan(kb(7) | kb(12) | kb(30), 1'b0, code(7, 12, 30), code(12, 0, 0));
      wr(PAGE_CTRL, ADDR_KEY_MASK_LOW, 16'h0000);
      wr(PAGE_CTRL, ADDR_KEY_MASK_HIGH, 16'h0000);
      $display("test key mask done");
      // Column disable removes column one from both words
      wr(PAGE_CTRL, ADDR_COLUMN_DISABLE, 16'hFFFF);
      rd(PAGE_CTRL, ADDR_COLUMN_DISABLE, 16'h003F);
      wr(PAGE_CTRL, ADDR_COLUMN_DISABLE, 16'h0001);
      scan(kb(3) | kb(8), 1'b0, code(8, 0, 0), code(8, 0, 0));
      wr(PAGE_CTRL, ADDR_COLUMN_DISABLE, 16'h0000);
      $display("test column done");
      // Host started scan
      host_scan_select_i = 1'b1;
      scan(kb(5) | kb(27), 1'b1, code(5, 27, 0), code(5, 27, 0));
      host_scan_select_i = 1'b0;
      $display("test host scan done");
      test_done();
   end
endmodule // test_keypad_mask_and_result_logic
